//--- pkg/ilc_pkg.sv
package ilc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam real CLOCK_MHZ = 20.0;
  localparam real PERIOD_MS = 39.8;
  // A fixed measurement period; whole cycles, rounded down
  localparam int PERIOD_CYCLES = int'($floor(PERIOD_MS * CLOCK_MHZ * 1000.0));
  localparam int PERIOD_CNT_W = 20;

  // ****************************************************************
  // Detector thresholds
  // ****************************************************************
  localparam logic [9:0] ERR_LIMIT = 10'h258;
  localparam logic [9:0] ERR_SAT = 10'h3FF;
  localparam logic [6:0] RUN_LIMIT = 7'h7E;
  localparam logic [6:0] RUN_SAT = 7'h7F;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_TX_CTRL = 8'h74;
  localparam logic [7:0] IDX_TX_CODE = 8'h75;
  localparam logic [7:0] IDX_DET_CFG = 8'h76;
  localparam logic [7:0] IDX_DET_STATE = 8'h77;
  localparam logic [7:0] IDX_ARM_CODE = 8'h78;
  localparam logic [7:0] IDX_REL_CODE = 8'h79;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h7A;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h7B;
  localparam int ADDR_W = 12;

  // ****************************************************************
  // Reset values and writable masks
  // ****************************************************************
  localparam logic [7:0] RST_TX_CTRL = 8'h00;
  localparam logic [7:0] RST_TX_CODE = 8'h00;
  localparam logic [7:0] RST_DET_CFG = 8'h04;
  localparam logic [7:0] RST_ARM_CODE = 8'h08;
  localparam logic [7:0] RST_REL_CODE = 8'h24;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] WMASK_TX_CTRL = 8'h0F;
  localparam logic [7:0] WMASK_DET_CFG = 8'h1F;
  localparam logic [7:0] WMASK_IRQ = 8'h03;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int TXC_ON_BIT = 3;
  localparam int TXC_UNFM_BIT = 2;
  localparam int TXC_LEN_LO = 0;
  localparam int CFG_SKIP_BIT = 4;
  localparam int CFG_REL_LEN_LO = 2;
  localparam int CFG_ARM_LEN_LO = 0;
  localparam int ARM_BIT = 1;
  localparam int REL_BIT = 0;

  // ****************************************************************
  // AXI responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- src/ilc_detector.sv
module ilc_detector (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Received stream
  input wire logic i_bit_valid,
  input wire logic i_bit,
  input wire logic i_fbit,
  // Configuration
  input wire logic i_skip_fbit,
  input wire logic [7:0] i_pattern,
  input wire logic [1:0] i_length,
  input wire logic i_period_end,
  // Status
  output logic o_present,
  output logic o_change
);
  import ilc_pkg::*;

  logic [7:0] hist;
  logic [2:0] ptr;
  logic [9:0] err;
  logic [6:0] run;
  logic [7:0] mask;
  logic [7:0] pat_v;
  logic [2:0] last;
  logic [7:0] next_hist;
  logic take;
  logic bit_err;
  logic [6:0] next_run;

  // ****************************************************************
  // Length selection
  // ****************************************************************
  always_comb begin
    case (i_length)
      2'h0: begin
        mask = 8'h1F;
        pat_v = {3'h0, i_pattern[7:3]};
        last = 3'h4;
      end
      2'h1: begin
        mask = 8'h3F;
        pat_v = {2'h0, i_pattern[7:2]};
        last = 3'h5;
      end
      2'h2: begin
        mask = 8'h7F;
        pat_v = {1'h0, i_pattern[7:1]};
        last = 3'h6;
      end
      default: begin
        mask = 8'hFF;
        pat_v = i_pattern;
        last = 3'h7;
      end
    endcase
  end

  // ****************************************************************
  // Bit comparison
  // ****************************************************************
  // Framing bits are skipped outright, or compared with the result dropped
  assign take = i_bit_valid && !(i_fbit && i_skip_fbit);
  assign next_hist = {hist[6:0], i_bit};
  // Expected bit walks from bit 7 downward; unused low bits never reached
  assign bit_err = take && !i_fbit && (i_bit != i_pattern[3'h7 - ptr]);
  assign next_run = (run == RUN_SAT) ? RUN_SAT : run + 7'h01;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      hist <= 8'h00;
      ptr <= 3'h0;
    end else if (take) begin
      hist <= next_hist;
      // A full window match re-aligns the phase to the pattern start
      if ((next_hist & mask) == pat_v) begin
        ptr <= 3'h0;
      end else if (ptr >= last) begin
        ptr <= 3'h0;
      end else begin
        ptr <= ptr + 3'h1;
      end
    end
  end

  // ****************************************************************
  // Period evaluation
  // ****************************************************************
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      err <= 10'h000;
    end else if (i_period_end) begin
      err <= bit_err ? 10'h001 : 10'h000;
    end else if (bit_err && err != ERR_SAT) begin
      err <= err + 10'h001;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      run <= 7'h00;
      o_present <= 1'b0;
      o_change <= 1'b0;
    end else begin
      o_change <= 1'b0;
      if (i_period_end) begin
        if (err > ERR_LIMIT) begin
          run <= 7'h00;
          o_present <= 1'b0;
          o_change <= o_present;
        end else if (err < ERR_LIMIT) begin
          run <= next_run;
          // Exactly the limit counts as neither good nor lost
          if (next_run > RUN_LIMIT) begin
            o_present <= 1'b1;
            o_change <= !o_present;
          end
        end else begin
          run <= 7'h00;
        end
      end
    end
  end

endmodule

//--- src/ilc_top.sv
module ilc_top #(
  parameter int P_PERIOD_CYCLES = ilc_pkg::PERIOD_CYCLES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // AXI4-Lite write address
  input wire logic [ilc_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ilc_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Transmit stream in
  input wire logic i_tx_valid,
  input wire logic i_tx_data,
  input wire logic i_tx_fbit,
  // Transmit stream out
  output logic o_tx_valid,
  output logic o_tx_data,
  output logic o_tx_fbit,
  // Receive stream
  input wire logic i_rx_valid,
  input wire logic i_rx_data,
  input wire logic i_rx_fbit,
  // Interrupt
  output logic o_irq
);
  import ilc_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] tx_ctrl;
  logic [7:0] tx_loop_pattern_code;
  logic [7:0] loop_detector_config;
  logic [7:0] arm_target_code;
  logic [7:0] release_target_code;
  logic [7:0] loop_detector_irq_mask;
  logic [7:0] loop_detector_irq_flags;
  logic [7:0] loop_detector_state;

  logic tx_loop_pattern_on;
  logic tx_loop_unframed_sel;
  logic [1:0] tx_loop_code_length;
  logic skip_framing_bit_compare;
  logic [1:0] arm_pattern_length;
  logic [1:0] release_pattern_length;
  logic arm_pattern_present;
  logic release_pattern_present;
  logic arm_change;
  logic release_change;

  assign tx_loop_pattern_on = tx_ctrl[TXC_ON_BIT];
  assign tx_loop_unframed_sel = tx_ctrl[TXC_UNFM_BIT];
  assign tx_loop_code_length = tx_ctrl[TXC_LEN_LO +: 2];
  assign skip_framing_bit_compare = loop_detector_config[CFG_SKIP_BIT];
  assign arm_pattern_length = loop_detector_config[CFG_ARM_LEN_LO +: 2];
  assign release_pattern_length = loop_detector_config[CFG_REL_LEN_LO +: 2];

  always_comb begin
    loop_detector_state = 8'h00;
    loop_detector_state[ARM_BIT] = arm_pattern_present;
    loop_detector_state[REL_BIT] = release_pattern_present;
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  // Address and data are caught independently, then one response
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [7:0] wr_idx;
  logic wr_hit;
  logic wr_lane;

  assign wr_fire = aw_held && w_held && !o_s_axi_bvalid;
  assign wr_idx = aw_addr[9:2];
  assign wr_lane = wr_fire && w_strb[0];
  assign wr_hit = (aw_addr[1:0] == 2'h0) && (aw_addr[ADDR_W-1:10] == 2'h0)
    && (wr_idx >= IDX_TX_CTRL) && (wr_idx <= IDX_IRQ_FLAGS);

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      o_s_axi_awready <= 1'b0;
    end else if (i_s_axi_awvalid && o_s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= i_s_axi_awaddr;
      o_s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end else begin
      o_s_axi_awready <= !aw_held && !o_s_axi_bvalid;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_s_axi_wready <= 1'b0;
    end else if (i_s_axi_wvalid && o_s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= i_s_axi_wdata;
      w_strb <= i_s_axi_wstrb;
      o_s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end else begin
      o_s_axi_wready <= !w_held && !o_s_axi_bvalid;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      o_s_axi_bvalid <= 1'b1;
      // Status register is read-only; writes to it are refused
      o_s_axi_bresp <= (wr_hit && wr_idx != IDX_DET_STATE) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      tx_ctrl <= RST_TX_CTRL;
      tx_loop_pattern_code <= RST_TX_CODE;
      loop_detector_config <= RST_DET_CFG;
      arm_target_code <= RST_ARM_CODE;
      release_target_code <= RST_REL_CODE;
      loop_detector_irq_mask <= RST_IRQ_MASK;
    end else if (wr_lane && wr_hit) begin
      case (wr_idx)
        IDX_TX_CTRL: tx_ctrl <= w_data[7:0] & WMASK_TX_CTRL;
        IDX_TX_CODE: tx_loop_pattern_code <= w_data[7:0];
        IDX_DET_CFG: loop_detector_config <= w_data[7:0] & WMASK_DET_CFG;
        IDX_ARM_CODE: arm_target_code <= w_data[7:0];
        IDX_REL_CODE: release_target_code <= w_data[7:0];
        IDX_IRQ_MASK: loop_detector_irq_mask <= w_data[7:0] & WMASK_IRQ;
        default: tx_ctrl <= tx_ctrl;
      endcase
    end
  end

  // ****************************************************************
  // Change flags and interrupt
  // ****************************************************************
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  always_comb begin
    flag_set = 8'h00;
    flag_set[ARM_BIT] = arm_change;
    flag_set[REL_BIT] = release_change;
    flag_clr = 8'h00;
    if (wr_lane && wr_hit && wr_idx == IDX_IRQ_FLAGS) begin
      flag_clr = w_data[7:0] & WMASK_IRQ;
    end
  end

  // A change in the same cycle as the clearing write is kept
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      loop_detector_irq_flags <= RST_IRQ_FLAGS;
    end else begin
      loop_detector_irq_flags <= (loop_detector_irq_flags & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(loop_detector_irq_flags & loop_detector_irq_mask);
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  logic [7:0] rd_idx;
  logic rd_hit;
  logic [7:0] rd_val;

  assign rd_idx = i_s_axi_araddr[9:2];
  assign rd_hit = (i_s_axi_araddr[1:0] == 2'h0) && (i_s_axi_araddr[ADDR_W-1:10] == 2'h0)
    && (rd_idx >= IDX_TX_CTRL) && (rd_idx <= IDX_IRQ_FLAGS);

  always_comb begin
    case (rd_idx)
      IDX_TX_CTRL: rd_val = tx_ctrl;
      IDX_TX_CODE: rd_val = tx_loop_pattern_code;
      IDX_DET_CFG: rd_val = loop_detector_config;
      IDX_DET_STATE: rd_val = loop_detector_state;
      IDX_ARM_CODE: rd_val = arm_target_code;
      IDX_REL_CODE: rd_val = release_target_code;
      IDX_IRQ_MASK: rd_val = loop_detector_irq_mask;
      IDX_IRQ_FLAGS: rd_val = loop_detector_irq_flags;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= rd_hit ? {24'h00_0000, rd_val} : 32'h0000_0000;
      o_s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (o_s_axi_rvalid) begin
      if (i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end else begin
      o_s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // Transmit pattern overwrite
  // ****************************************************************
  logic [2:0] tx_ptr;
  logic [2:0] tx_last;
  logic tx_over;

  // Lowest valid bit index is 3, 2, 1 or 0 by the length field
  assign tx_last = 3'h4 + {1'b0, tx_loop_code_length};
  assign tx_over = tx_loop_pattern_on && (!i_tx_fbit || tx_loop_unframed_sel);

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      tx_ptr <= 3'h0;
    end else if (!tx_loop_pattern_on) begin
      tx_ptr <= 3'h0;
    end else if (i_tx_valid && tx_over) begin
      tx_ptr <= (tx_ptr >= tx_last) ? 3'h0 : tx_ptr + 3'h1;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_tx_valid <= 1'b0;
      o_tx_data <= 1'b0;
      o_tx_fbit <= 1'b0;
    end else begin
      o_tx_valid <= i_tx_valid;
      o_tx_fbit <= i_tx_fbit;
      o_tx_data <= tx_over ? tx_loop_pattern_code[3'h7 - tx_ptr] : i_tx_data;
    end
  end

  // ****************************************************************
  // Measurement period and detectors
  // ****************************************************************
  // Free-running period, not aligned to any pattern event
  logic [PERIOD_CNT_W-1:0] period_cnt;
  logic period_end;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      period_cnt <= '0;
      period_end <= 1'b0;
    end else if (period_cnt >= PERIOD_CNT_W'(P_PERIOD_CYCLES - 1)) begin
      period_cnt <= '0;
      period_end <= 1'b1;
    end else begin
      period_cnt <= period_cnt + PERIOD_CNT_W'(1);
      period_end <= 1'b0;
    end
  end

  ilc_detector u_arm (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_bit_valid(i_rx_valid),
    .i_bit(i_rx_data),
    .i_fbit(i_rx_fbit),
    .i_skip_fbit(skip_framing_bit_compare),
    .i_pattern(arm_target_code),
    .i_length(arm_pattern_length),
    .i_period_end(period_end),
    .o_present(arm_pattern_present),
    .o_change(arm_change)
  );

  ilc_detector u_release (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_bit_valid(i_rx_valid),
    .i_bit(i_rx_data),
    .i_fbit(i_rx_fbit),
    .i_skip_fbit(skip_framing_bit_compare),
    .i_pattern(release_target_code),
    .i_length(release_pattern_length),
    .i_period_end(period_end),
    .o_present(release_pattern_present),
    .o_change(release_change)
  );

endmodule

//--- bench/ilc_top_props.sv
// ****************************************************************
// Port checks for the loopback code block
// ****************************************************************
module ilc_top_props #(
  parameter int P_PERIOD_CYCLES = 1000
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Register bus
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [ilc_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0] o_s_axi_rresp,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Streams and interrupt
  input wire logic i_tx_valid,
  input wire logic i_tx_fbit,
  input wire logic o_tx_valid,
  input wire logic o_tx_fbit,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  import ilc_pkg::*;
  int phase;
  logic [2:0] b_age;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  // Phase in the period; status only moves just after a tick
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      phase <= 0;
    end else if (phase == P_PERIOD_CYCLES - 1) begin
      phase <= 0;
    end else begin
      phase <= phase + 1;
    end
  end
  // Age of the last write answer, so mask writes may move the interrupt
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      b_age <= 3'h7;
    end else if (o_s_axi_bvalid) begin
      b_age <= 3'h0;
    end else if (b_age != 3'h7) begin
      b_age <= b_age + 3'h1;
    end
  end
  tx_align_a: assert property (
    i_tx_valid |=> o_tx_valid && o_tx_fbit == $past(i_tx_fbit))
    else $error("stream output not one cycle behind input");
  tx_idle_a: assert property (
    !i_tx_valid |=> !o_tx_valid)
    else $error("stream output without input bit");
  irq_timing_a: assert property (
    $rose(o_irq) |-> phase < 8 || o_s_axi_bvalid || b_age < 3'h4)
    else $error("interrupt rose away from tick or write");
  bresp_hold_a: assert property (
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
    else $error("write answer dropped early");
  rdata_hold_a: assert property (
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read answer changed before taken");
  read_lat_a: assert property (
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
  ar_block_a: assert property (
    o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read address taken while answer pending");
  unmapped_a: assert property (
    i_s_axi_arvalid && o_s_axi_arready && (i_s_axi_araddr < 12'h1D0 || i_s_axi_araddr > 12'h1EC)
    |=> o_s_axi_rresp == RESP_SLVERR && o_s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule
bind ilc_top ilc_top_props #(.P_PERIOD_CYCLES(P_PERIOD_CYCLES)) u_props (
  .i_clock(i_clock), .i_reset(i_reset), .o_s_axi_bvalid(o_s_axi_bvalid),
  .i_s_axi_bready(i_s_axi_bready), .i_s_axi_araddr(i_s_axi_araddr),
  .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp),
  .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
  .i_tx_valid(i_tx_valid), .i_tx_fbit(i_tx_fbit), .o_tx_valid(o_tx_valid),
  .o_tx_fbit(o_tx_fbit), .o_irq(o_irq)
);

//--- bench/ilc_remote.sv
// ****************************************************************
// Remote terminal sending a steady line code
// ****************************************************************
module ilc_remote (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Control
  input wire logic i_send_ones,
  // Line towards the receiver
  output logic o_rx_valid,
  output logic o_rx_data,
  output logic o_rx_fbit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] slot;
  // Slot 0 of 193 is framing, sent wrong so it must never count as an error
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      slot <= 8'h00;
      o_rx_valid <= 1'b0;
      o_rx_data <= 1'b0;
      o_rx_fbit <= 1'b0;
    end else begin
      slot <= (slot == 8'hC0) ? 8'h00 : slot + 8'h01;
      o_rx_valid <= 1'b1;
      o_rx_fbit <= (slot == 8'h00);
      o_rx_data <= (slot == 8'h00) ? ~i_send_ones : i_send_ones;
    end
  end
endmodule

//--- bench/tb.sv
// ****************************************************************
// Register, transmit and detection tests
// ****************************************************************
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ilc_pkg::*;
  // Short period keeps 127 good periods inside the run
  localparam int PER = 650;
  localparam logic [7:0] TXC = 8'hB5;
  logic i_clock, i_reset, awvalid, wvalid, bready, arvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic tx_valid, tx_data, tx_fbit, send_ones;
  wire logic awready, wready, bvalid, arready, rvalid, o_tx_valid, o_tx_data, o_tx_fbit, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic rx_valid, rx_data, rx_fbit;
  int mismatches, check_count, cyc;
  ilc_top #(.P_PERIOD_CYCLES(PER)) uut (
    .i_clock(i_clock), .i_reset(i_reset),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_tx_fbit(tx_fbit),
    .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_fbit(o_tx_fbit),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_fbit(rx_fbit), .o_irq(irq)
  );
  ilc_remote u_remote (
    .i_clock(i_clock), .i_reset(i_reset), .i_send_ones(send_ones),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_fbit(rx_fbit)
  );
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc <= i_reset ? 0 : cyc + 1;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic timeout;
    mismatches++;
    $display("BAD t=%0t wait ran out", $time);
    stop_test();
  endtask
  // Handshakes are judged at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r);
    logic a, w, b;
    logic [1:0] got;
    int n;
    n = 0;
    b = 1'b0;
    @(posedge i_clock);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge i_clock);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      got = bresp;
      @(posedge i_clock);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      n++;
      if (n > 40) timeout();
    end
    bready <= 1'b0;
    chk({30'h0, got}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] r);
    logic a, v;
    logic [31:0] got;
    logic [1:0] gr;
    int n;
    n = 0;
    v = 1'b0;
    @(posedge i_clock);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!v) begin
      @(negedge i_clock);
      a = arvalid && arready;
      v = rvalid;
      got = rdata;
      gr = rresp;
      @(posedge i_clock);
      if (a) arvalid <= 1'b0;
      n++;
      if (n > 40) timeout();
    end
    rready <= 1'b0;
    chk(got, {24'h0, e});
    chk({30'h0, gr}, {30'h0, r});
  endtask
  task automatic txb(input logic d, input logic f, input logic e);
    @(posedge i_clock);
    tx_valid <= 1'b1;
    tx_data <= d;
    tx_fbit <= f;
    @(posedge i_clock);
    tx_valid <= 1'b0;
    #1;
    chk({31'h0, o_tx_valid}, 32'h1);
    chk({31'h0, o_tx_data}, {31'h0, e});
  endtask
  task automatic chk_irq(input logic e);
    #1;
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1) begin
      @(negedge i_clock);
      n++;
      if (n > lim) timeout();
    end
  endtask
  initial begin
    i_reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hF;
    {tx_valid, tx_data, tx_fbit, send_ones} = 4'h0;
    mismatches = 0;
    check_count = 0;
    repeat (12) @(posedge i_clock);
    i_reset <= 1'b0;
    rd(IDX_TX_CTRL, 8'h00, RESP_OKAY);
    rd(IDX_TX_CODE, 8'h00, RESP_OKAY);
    rd(IDX_DET_CFG, 8'h04, RESP_OKAY);
    rd(IDX_ARM_CODE, 8'h08, RESP_OKAY);
    rd(IDX_REL_CODE, 8'h24, RESP_OKAY);
    rd(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
    rd(IDX_IRQ_FLAGS, 8'h00, RESP_OKAY);
    wr(IDX_DET_CFG, 8'hFF, RESP_OKAY);
    rd(IDX_DET_CFG, 8'h1F, RESP_OKAY);
    wr(IDX_DET_STATE, 8'hFF, RESP_SLVERR);
    rd(IDX_DET_STATE, 8'h00, RESP_OKAY);
    rd(8'h7C, 8'h00, RESP_SLVERR);
    wr(8'h7C, 8'h00, RESP_SLVERR);
    wstrb <= 4'h0;
    wr(IDX_IRQ_MASK, 8'h03, RESP_OKAY);
    wstrb <= 4'hF;
    rd(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
    $display("register test done");
    wr(IDX_ARM_CODE, 8'hF8, RESP_OKAY);
    wr(IDX_REL_CODE, 8'hF8, RESP_OKAY);
    wr(IDX_DET_CFG, 8'h00, RESP_OKAY);
    wr(IDX_IRQ_MASK, 8'h02, RESP_OKAY);
    send_ones <= 1'b1;
    wr(IDX_TX_CODE, TXC, RESP_OKAY);
    for (int l = 0; l < 4; l++) begin
      wr(IDX_TX_CTRL, 8'h00, RESP_OKAY);
      txb(1'b0, 1'b0, 1'b0);
      wr(IDX_TX_CTRL, 8'h08 | 8'(l), RESP_OKAY);
      for (int k = 0; k < 2 * (l + 5); k++) begin
        if (k == 3) txb(1'b0, 1'b1, 1'b0);
        txb(1'b1, 1'b0, TXC[7 - k % (l + 5)]);
      end
    end
    wr(IDX_TX_CTRL, 8'h0C, RESP_OKAY);
    txb(1'b0, 1'b1, 1'b1);
    txb(1'b1, 1'b0, 1'b0);
    wr(IDX_TX_CTRL, 8'h00, RESP_OKAY);
    $display("transmit test done");
    rd(IDX_DET_STATE, 8'h00, RESP_OKAY);
    wait_irq(135 * PER);
    chk({31'h0, cyc > 127 * PER && cyc < 128 * PER}, 32'h1);
    rd(IDX_DET_STATE, 8'h03, RESP_OKAY);
    rd(IDX_IRQ_FLAGS, 8'h03, RESP_OKAY);
    wr(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
    chk_irq(1'b0);
    wr(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
    chk_irq(1'b1);
    wr(IDX_IRQ_FLAGS, 8'h02, RESP_OKAY);
    rd(IDX_IRQ_FLAGS, 8'h01, RESP_OKAY);
    wr(IDX_IRQ_FLAGS, 8'h01, RESP_OKAY);
    chk_irq(1'b0);
    rd(IDX_IRQ_FLAGS, 8'h00, RESP_OKAY);
    $display("detect test done");
    wr(IDX_DET_CFG, 8'h10, RESP_OKAY);
    send_ones <= 1'b0;
    wait_irq(3 * PER);
    rd(IDX_DET_STATE, 8'h00, RESP_OKAY);
    rd(IDX_IRQ_FLAGS, 8'h03, RESP_OKAY);
    $display("loss test done");
    stop_test();
  end
endmodule
